//--- hw/dfp_top.sv
// Fault and protection supervisor with APB register access
`timescale 1ns/100ps
module dfp_top #(
  parameter int MS_CYCLES = dfp_pkg::MS_CYCLES
) (
  // Clock and reset
  input  wire logic        REF_CLK_I,
  input  wire logic        RESET_N_I,
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // Drive measurements and ramp state
  input  wire logic [15:0] OUT_FREQ_I,
  input  wire logic [15:0] OUT_CURRENT_I,
  input  wire logic [15:0] BUS_VOLTAGE_I,
  input  wire logic        ACCEL_I,
  input  wire logic        DECEL_I,
  // Fault sources
  input  wire logic        FAULT_EVENT_I,
  input  wire logic [7:0]  FAULT_CODE_I,
  input  wire logic        INPUT_PHASE_LOSS_I,
  input  wire logic        CONTACTOR_FAULT_I,
  input  wire logic        OUTPUT_PHASE_LOSS_I,
  // Terminals
  input  wire logic [9:0]  LOGIC_INPUT_TERMINAL_I,
  input  wire logic [4:0]  OUT_TERMINALS_I,
  // Model straps
  input  wire logic [2:0]  VOLTAGE_CLASS_I,
  input  wire logic        POWER_QUALIFIED_I,
  // Protection outputs
  output logic             OVERLOAD_WARN_O,
  output logic             RAMP_HOLD_O,
  output logic             MOTOR_PHASE_OUTPUTS_EN_O,
  output logic             FAULT_ACTIVE_O,
  output logic             FAULT_TERMINAL_O,
  output logic             FAULT_RESET_O
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [15:0]        warn_coef_q, ov_gain_q, ov_thr_q, oc_gain_q, oc_thr_q;
  logic [15:0]        retries_q, phase_sel_q, interval_q, ol_gain_q;
  logic               act_on_reset_q, gnd_en_q, out_phase_en_q;
  logic [9:0]         din_meta_q, din_sync_q;
  logic [2:0]         vclass_q;
  logic               qualified_q, strap_done_q;
  logic [31:0]        ms_cnt_q;
  logic               ms_tick;
  logic [47:0]        ol_acc_q;
  logic [47:0]        ol_level;
  logic signed [31:0] ol_rate;
  logic               ol_trip, ol_warn_q;
  logic [15:0]        ov_base;
  logic               ov_hold_q, oc_hold_q;
  logic [15:0]        gnd_ms_q;
  logic               gnd_on_q;
  dfp_pkg::dfp_state_t state_q;
  logic [4:0]         reset_cnt_q;
  logic [16:0]        wait_ms_q;
  logic               reset_pulse_q;
  logic [7:0]         ft_first_q, ft_second_q, ft_last_q;
  logic [15:0]        snap_frq_q, snap_cur_q, snap_bus_q;
  logic [9:0]         snap_in_q;
  logic [4:0]         snap_out_q;
  logic               fault_new, in_phase_on, contact_on;
  logic [7:0]         fault_code;
  logic               wr_en, clr_req;
  logic [31:0]        rdata_d;
  logic               rd_err;

  function automatic logic [15:0] clip(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    clip = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  assign wr_en   = PSEL_I & PENABLE_I & PWRITE_I;
  assign clr_req = wr_en & (PADDR_I == dfp_pkg::OFS_CTRL) & PWDATA_I[0];

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      warn_coef_q    <= dfp_pkg::RST_WARN_COEF;
      ov_gain_q      <= dfp_pkg::RST_OV_GAIN;
      ov_thr_q       <= dfp_pkg::RST_OV_THR;
      oc_gain_q      <= dfp_pkg::RST_OC_GAIN;
      oc_thr_q       <= dfp_pkg::RST_OC_THR;
      retries_q      <= dfp_pkg::RST_RETRIES;
      phase_sel_q    <= dfp_pkg::RST_PHASE_SEL;
      interval_q     <= dfp_pkg::RST_INTERVAL;
      ol_gain_q      <= dfp_pkg::RST_OL_GAIN;
      act_on_reset_q <= 1'b0;
      gnd_en_q       <= 1'b1;
      out_phase_en_q <= 1'b1;
    end else if (wr_en) begin
      unique case (PADDR_I)
        dfp_pkg::OFS_CFG0: begin
          warn_coef_q <= clip({9'h000, PWDATA_I[6:0]}, dfp_pkg::WARN_MIN, dfp_pkg::WARN_MAX);
          ov_gain_q   <= clip({8'h00, PWDATA_I[15:8]}, 16'h0000, dfp_pkg::GAIN_MAX);
          ov_thr_q    <= clip({8'h00, PWDATA_I[23:16]}, dfp_pkg::OV_THR_MIN, dfp_pkg::OV_THR_MAX);
        end
        dfp_pkg::OFS_CFG1: begin
          oc_gain_q <= clip({8'h00, PWDATA_I[7:0]}, 16'h0000, dfp_pkg::GAIN_MAX);
          oc_thr_q  <= clip({8'h00, PWDATA_I[15:8]}, dfp_pkg::OC_THR_MIN, dfp_pkg::OC_THR_MAX);
        end
        dfp_pkg::OFS_CFG2: begin
          retries_q      <= clip({11'h000, PWDATA_I[4:0]}, 16'h0000, dfp_pkg::RETRIES_MAX);
          act_on_reset_q <= PWDATA_I[8];
          gnd_en_q       <= PWDATA_I[9];
          out_phase_en_q <= PWDATA_I[10];
          phase_sel_q    <= clip({8'h00, PWDATA_I[23:16]}, 16'h0000, dfp_pkg::PHASE_SEL_MAX);
        end
        dfp_pkg::OFS_INTERVAL: begin
          interval_q <= clip(PWDATA_I[15:0], dfp_pkg::INTERVAL_MIN, dfp_pkg::INTERVAL_MAX);
        end
        dfp_pkg::OFS_OL_GAIN: begin
          ol_gain_q <= clip(PWDATA_I[15:0], dfp_pkg::OL_GAIN_MIN, dfp_pkg::OL_GAIN_MAX);
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Input sync and straps
  // ----------------------------------------
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      din_meta_q <= 10'h000;
      din_sync_q <= 10'h000;
    end else begin
      din_meta_q <= LOGIC_INPUT_TERMINAL_I;
      din_sync_q <= din_meta_q;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      vclass_q     <= 3'h0;
      qualified_q  <= 1'b0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      vclass_q     <= VOLTAGE_CLASS_I;
      qualified_q  <= POWER_QUALIFIED_I;
      strap_done_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Millisecond tick
  // ----------------------------------------
  assign ms_tick = (ms_cnt_q == 32'(MS_CYCLES - 1));

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ms_cnt_q <= 32'h0000_0000;
    end else begin
      ms_cnt_q <= ms_tick ? 32'h0000_0000 : ms_cnt_q + 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // Overload inverse-time accumulator
  // ----------------------------------------
  assign ol_rate  = $signed({16'h0000, OUT_CURRENT_I}) * 32'sd100
                  - $signed({16'h0000, dfp_pkg::OL_KNEE}) * $signed({16'h0000, ol_gain_q});
  assign ol_level = 48'(dfp_pkg::OL_LEVEL * ol_gain_q);
  assign ol_trip  = (ol_acc_q >= ol_level);

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ol_acc_q <= 48'h0000_0000_0000;
    end else if (ms_tick) begin
      if (ol_rate >= 0) begin
        ol_acc_q <= ol_trip ? ol_acc_q : ol_acc_q + 48'(ol_rate);
      end else begin
        ol_acc_q <= (ol_acc_q > 48'(-ol_rate)) ? ol_acc_q - 48'(-ol_rate) : 48'h0000_0000_0000;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ol_warn_q <= 1'b0;
    end else begin
      ol_warn_q <= (56'(ol_acc_q) * 56'd100) > (56'(ol_level) * 56'(warn_coef_q));
    end
  end

  // ----------------------------------------
  // Stall suppression
  // ----------------------------------------
  always_comb begin
    unique case (vclass_q)
      3'h2:    ov_base = dfp_pkg::BASE_380;
      3'h3:    ov_base = dfp_pkg::BASE_480;
      3'h4:    ov_base = dfp_pkg::BASE_690;
      default: ov_base = dfp_pkg::BASE_220;
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ov_hold_q <= 1'b0;
      oc_hold_q <= 1'b0;
    end else begin
      ov_hold_q <= (ov_gain_q != 16'h0000) & DECEL_I
                 & ((32'(BUS_VOLTAGE_I) * 32'd100) > (32'(ov_base) * 32'(ov_thr_q)));
      oc_hold_q <= (oc_gain_q != 16'h0000) & (ACCEL_I | DECEL_I)
                 & (32'(OUT_CURRENT_I) > (32'(oc_thr_q) * 32'd10));
    end
  end

  // ----------------------------------------
  // Power-on ground check
  // ----------------------------------------
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      gnd_ms_q <= 16'h0000;
      gnd_on_q <= 1'b0;
    end else if (ms_tick && gnd_ms_q != 16'(dfp_pkg::GND_DELAY_MS + dfp_pkg::GND_PULSE_MS)) begin
      gnd_ms_q <= gnd_ms_q + 16'h0001;
      gnd_on_q <= gnd_en_q & (gnd_ms_q >= 16'(dfp_pkg::GND_DELAY_MS - 1))
                & (gnd_ms_q < 16'(dfp_pkg::GND_DELAY_MS + dfp_pkg::GND_PULSE_MS - 1));
    end
  end

  // ----------------------------------------
  // Fault detection
  // ----------------------------------------
  assign in_phase_on = qualified_q & (phase_sel_q % 16'd10 != 16'h0000);
  assign contact_on  = qualified_q & (phase_sel_q / 16'd10 != 16'h0000);

  always_comb begin
    fault_new  = 1'b1;
    fault_code = 8'h00;
    if (FAULT_EVENT_I && FAULT_CODE_I != 8'h00) begin
      fault_code = 8'(clip({8'h00, FAULT_CODE_I}, 16'h0001, dfp_pkg::CODE_MAX));
    end else if (ol_trip) begin
      fault_code = dfp_pkg::FC_OVERLOAD;
    end else if (INPUT_PHASE_LOSS_I && in_phase_on) begin
      fault_code = dfp_pkg::FC_IN_PHASE;
    end else if (CONTACTOR_FAULT_I && contact_on) begin
      fault_code = dfp_pkg::FC_CONTACT;
    end else if (OUTPUT_PHASE_LOSS_I && out_phase_en_q) begin
      fault_code = dfp_pkg::FC_OUT_PHAS;
    end else begin
      fault_new = 1'b0;
    end
    fault_new = fault_new & (state_q == dfp_pkg::ST_IDLE);
  end

  // ----------------------------------------
  // Fault state and auto-reset
  // ----------------------------------------
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state_q       <= dfp_pkg::ST_IDLE;
      reset_cnt_q   <= 5'h00;
      wait_ms_q     <= 17'h00000;
      reset_pulse_q <= 1'b0;
    end else begin
      reset_pulse_q <= 1'b0;
      wait_ms_q     <= 17'h00000;
      unique case (state_q)
        dfp_pkg::ST_IDLE: begin
          if (fault_new) begin
            state_q <= (16'(reset_cnt_q) < retries_q) ? dfp_pkg::ST_WAIT : dfp_pkg::ST_LOCKED;
          end else if (clr_req) begin
            reset_cnt_q <= 5'h00;
          end
        end
        dfp_pkg::ST_WAIT: begin
          wait_ms_q <= wait_ms_q + (ms_tick ? 17'h00001 : 17'h00000);
          if (clr_req) begin
            state_q       <= dfp_pkg::ST_IDLE;
            reset_cnt_q   <= 5'h00;
            reset_pulse_q <= 1'b1;
          end else if (ms_tick && wait_ms_q == 17'(32'(interval_q) * dfp_pkg::RETRY_UNIT_MS - 1)) begin
            state_q       <= dfp_pkg::ST_IDLE;
            reset_cnt_q   <= reset_cnt_q + 5'h01;
            reset_pulse_q <= 1'b1;
          end
        end
        dfp_pkg::ST_LOCKED: begin
          if (clr_req) begin
            state_q       <= dfp_pkg::ST_IDLE;
            reset_cnt_q   <= 5'h00;
            reset_pulse_q <= 1'b1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Fault history and snapshots
  // ----------------------------------------
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ft_first_q  <= 8'h00;
      ft_second_q <= 8'h00;
      ft_last_q   <= 8'h00;
      snap_frq_q  <= 16'h0000;
      snap_cur_q  <= 16'h0000;
      snap_bus_q  <= 16'h0000;
      snap_in_q   <= 10'h000;
      snap_out_q  <= 5'h00;
    end else if (fault_new) begin
      ft_first_q  <= ft_second_q;
      ft_second_q <= ft_last_q;
      ft_last_q   <= fault_code;
      snap_frq_q  <= OUT_FREQ_I;
      snap_cur_q  <= OUT_CURRENT_I;
      snap_bus_q  <= BUS_VOLTAGE_I;
      snap_in_q   <= {din_sync_q[0], din_sync_q[9:1]};
      snap_out_q  <= OUT_TERMINALS_I;
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  always_comb begin
    rdata_d = 32'h0000_0000;
    rd_err  = 1'b0;
    unique case (PADDR_I)
      dfp_pkg::OFS_CFG0:     rdata_d = {8'h00, ov_thr_q[7:0], ov_gain_q[7:0], warn_coef_q[7:0]};
      dfp_pkg::OFS_CFG1:     rdata_d = {16'h0000, oc_thr_q[7:0], oc_gain_q[7:0]};
      dfp_pkg::OFS_CFG2:     rdata_d = {8'h00, phase_sel_q[7:0], 5'h00, out_phase_en_q, gnd_en_q,
                                        act_on_reset_q, 3'h0, retries_q[4:0]};
      dfp_pkg::OFS_INTERVAL: rdata_d = {16'h0000, interval_q};
      dfp_pkg::OFS_OL_GAIN:  rdata_d = {16'h0000, ol_gain_q};
      dfp_pkg::OFS_CTRL:     rdata_d = 32'h0000_0000;
      dfp_pkg::OFS_STATUS:   rdata_d = {19'h00000, reset_cnt_q, 2'(state_q), ov_hold_q, oc_hold_q,
                                        ol_warn_q, ol_trip, gnd_on_q, qualified_q};
      dfp_pkg::OFS_FT_FIRST: rdata_d = {24'h000000, ft_first_q};
      dfp_pkg::OFS_FT_SECND: rdata_d = {24'h000000, ft_second_q};
      dfp_pkg::OFS_FT_LAST:  rdata_d = {24'h000000, ft_last_q};
      dfp_pkg::OFS_SNAP_FRQ: rdata_d = {16'h0000, snap_frq_q};
      dfp_pkg::OFS_SNAP_CUR: rdata_d = {16'h0000, snap_cur_q};
      dfp_pkg::OFS_SNAP_BUS: rdata_d = {16'h0000, snap_bus_q};
      dfp_pkg::OFS_SNAP_IN:  rdata_d = {22'h000000, snap_in_q};
      dfp_pkg::OFS_SNAP_OUT: rdata_d = {27'h0000000, snap_out_q};
      default:               rd_err  = 1'b1;
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      PRDATA_O <= rdata_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign PREADY_O                 = PSEL_I & PENABLE_I;
  assign PSLVERR_O                = PSEL_I & PENABLE_I & rd_err;
  assign OVERLOAD_WARN_O          = ol_warn_q;
  assign RAMP_HOLD_O              = ov_hold_q | oc_hold_q;
  assign MOTOR_PHASE_OUTPUTS_EN_O = gnd_on_q;
  assign FAULT_ACTIVE_O           = (state_q != dfp_pkg::ST_IDLE);
  assign FAULT_TERMINAL_O         = (state_q == dfp_pkg::ST_LOCKED)
                                  | ((state_q == dfp_pkg::ST_WAIT) & act_on_reset_q);
  assign FAULT_RESET_O            = reset_pulse_q;
endmodule // dfp_top

//--- hw/dfp_pkg.sv
// Constants and types of the drive fault and protection supervisor
// Function
// - Pre-warning output goes on when overload accumulation passes curve times warning coefficient.
// - Warning coefficient is 50 to 100 percent, reset 80; larger warns later.
// - While decelerating, bus voltage above threshold holds the running frequency.
// - Deceleration resumes once bus voltage falls back below the threshold.
// - Overvoltage stall gain 0 to 100, reset 0; zero disables the stall.
// - Overvoltage threshold base is 290, 530, 620 or 880 V by class.
// - Ramping with current above 100 to 200 percent threshold holds frequency.
// - Ramp resumes once output current falls back below the threshold.
// - Overcurrent stall gain 0 to 100, reset 20; zero disables the stall.
// - Enabled by default, motor phases are briefly energised after power-on to check ground.
// - Auto-resets happen up to the set count 0 to 20, then fault stays.
// - During auto-reset the fault terminal stays off for 0, acts for 1.
// - Auto-reset waits 0.1 to 100.0 s after the fault, reset 1.0 s.
// - Units digit enables input phase loss, tens digit contactor protection; both default on.
// - Below the qualifying power rating neither input phase loss nor contactor protection acts.
// - Output phase-loss protection acts only when its enable is 1, the default.
// - Three latest fault codes 0 to 99 are kept; 0 means no fault.
// - Frequency, current and bus voltage are captured at the latest fault.
// - Inputs one to nine land in bits 0 to 8, input zero in bit 9.
// - Pulse output bit 0, contacts bits 1 and 2, switched outputs bits 3, 4.
// - Curve trips after one minute at 220 or an hour at 150 percent times gain.
package dfp_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GND_DELAY_MS  = 100;
  localparam int GND_PULSE_MS  = 10;
  localparam int RETRY_UNIT_MS = 100;
  // ----------------------------------------
  // Overload curve, current in 0.1 percent
  // ----------------------------------------
  localparam logic [15:0] OL_KNEE    = 16'h05d0;
  localparam logic [15:0] OL_HOT     = 16'h0898;
  localparam longint      OL_HOT_MS  = 60000;
  localparam logic [47:0] OL_LEVEL   = 48'(longint'(OL_HOT - OL_KNEE) * OL_HOT_MS);
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CFG0     = 8'h00;
  localparam logic [7:0] OFS_CFG1     = 8'h04;
  localparam logic [7:0] OFS_CFG2     = 8'h08;
  localparam logic [7:0] OFS_INTERVAL = 8'h0c;
  localparam logic [7:0] OFS_OL_GAIN  = 8'h10;
  localparam logic [7:0] OFS_CTRL     = 8'h14;
  localparam logic [7:0] OFS_STATUS   = 8'h18;
  localparam logic [7:0] OFS_FT_FIRST = 8'h20;
  localparam logic [7:0] OFS_FT_SECND = 8'h24;
  localparam logic [7:0] OFS_FT_LAST  = 8'h28;
  localparam logic [7:0] OFS_SNAP_FRQ = 8'h2c;
  localparam logic [7:0] OFS_SNAP_CUR = 8'h30;
  localparam logic [7:0] OFS_SNAP_BUS = 8'h34;
  localparam logic [7:0] OFS_SNAP_IN  = 8'h38;
  localparam logic [7:0] OFS_SNAP_OUT = 8'h3c;
  // ----------------------------------------
  // Reset values and ranges
  // ----------------------------------------
  localparam logic [15:0] RST_WARN_COEF = 16'h0050;
  localparam logic [15:0] WARN_MIN      = 16'h0032;
  localparam logic [15:0] WARN_MAX      = 16'h0064;
  localparam logic [15:0] RST_OV_GAIN   = 16'h0000;
  localparam logic [15:0] RST_OV_THR    = 16'h0082;
  localparam logic [15:0] OV_THR_MIN    = 16'h0078;
  localparam logic [15:0] OV_THR_MAX    = 16'h0096;
  localparam logic [15:0] RST_OC_GAIN   = 16'h0014;
  localparam logic [15:0] GAIN_MAX      = 16'h0064;
  localparam logic [15:0] RST_OC_THR    = 16'h0096;
  localparam logic [15:0] OC_THR_MIN    = 16'h0064;
  localparam logic [15:0] OC_THR_MAX    = 16'h00c8;
  localparam logic [15:0] RST_RETRIES   = 16'h0000;
  localparam logic [15:0] RETRIES_MAX   = 16'h0014;
  localparam logic [15:0] RST_PHASE_SEL = 16'h000b;
  localparam logic [15:0] PHASE_SEL_MAX = 16'h0063;
  localparam logic [15:0] RST_INTERVAL  = 16'h000a;
  localparam logic [15:0] INTERVAL_MIN  = 16'h0001;
  localparam logic [15:0] INTERVAL_MAX  = 16'h03e8;
  localparam logic [15:0] RST_OL_GAIN   = 16'h0064;
  localparam logic [15:0] OL_GAIN_MIN   = 16'h0014;
  localparam logic [15:0] OL_GAIN_MAX   = 16'h03e8;
  localparam logic [15:0] CODE_MAX      = 16'h0063;
  // ----------------------------------------
  // Bus voltage base per class, in volts
  // ----------------------------------------
  localparam logic [15:0] BASE_220 = 16'h0122;
  localparam logic [15:0] BASE_380 = 16'h0212;
  localparam logic [15:0] BASE_480 = 16'h026c;
  localparam logic [15:0] BASE_690 = 16'h0370;
  // ----------------------------------------
  // Internal fault codes
  // ----------------------------------------
  localparam logic [7:0] FC_OVERLOAD = 8'h0b;
  localparam logic [7:0] FC_IN_PHASE = 8'h0c;
  localparam logic [7:0] FC_OUT_PHAS = 8'h0d;
  localparam logic [7:0] FC_CONTACT  = 8'h0e;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_LOCKED} dfp_state_t;
endpackage

//--- sim/dfp_drive_model.sv
// Ramp generator model that stops ramping while the supervisor holds it
`timescale 1ns/100ps
module dfp_drive_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        hold_i,
  input  wire logic [15:0] target_i,
  output logic      [15:0] freq_o,
  output logic             accel_o,
  output logic             decel_o
);
  assign accel_o = freq_o < target_i;
  assign decel_o = freq_o > target_i;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) freq_o <= 16'h0000;
    else if (!hold_i && accel_o) freq_o <= freq_o + 16'h0001;
    else if (!hold_i && decel_o) freq_o <= freq_o - 16'h0001;
  end
endmodule // dfp_drive_model

//--- sim/dfp_assertions.sv
// Port level assertions of the fault supervisor
`timescale 1ns/100ps
module dfp_assertions #(
  parameter int MS_CYCLES = 10
) (
  input wire logic        REF_CLK_I,
  input wire logic        RESET_N_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic [15:0] OUT_CURRENT_I,
  input wire logic [15:0] BUS_VOLTAGE_I,
  input wire logic        ACCEL_I,
  input wire logic        DECEL_I,
  input wire logic        RAMP_HOLD_O,
  input wire logic        MOTOR_PHASE_OUTPUTS_EN_O,
  input wire logic        FAULT_ACTIVE_O,
  input wire logic        FAULT_TERMINAL_O,
  input wire logic        FAULT_RESET_O
);
  localparam int GND_W = dfp_pkg::GND_PULSE_MS * MS_CYCLES;
  int gnd_q;
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) gnd_q <= 0;
    else if (MOTOR_PHASE_OUTPUTS_EN_O) gnd_q <= gnd_q + 1;
    else gnd_q <= 0;
  end
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  AST_READY: assert property (PSEL_I && PENABLE_I |-> PREADY_O)
    else $error("access without ready");
  AST_SLVERR: assert property (PSLVERR_O |-> PSEL_I && PENABLE_I)
    else $error("error outside access");
  AST_HOLD_RAMP: assert property (RAMP_HOLD_O |-> $past(ACCEL_I || DECEL_I))
    else $error("hold while not ramping");
  AST_OC_REL: assert property (ACCEL_I && !DECEL_I && OUT_CURRENT_I <= 16'h03e8 |=> !RAMP_HOLD_O)
    else $error("hold at low current");
  AST_OV_REL: assert property (DECEL_I && BUS_VOLTAGE_I <= 16'h015c && OUT_CURRENT_I <= 16'h03e8 |=> !RAMP_HOLD_O)
    else $error("hold at low bus voltage");
  AST_TERM: assert property (FAULT_TERMINAL_O |-> FAULT_ACTIVE_O)
    else $error("fault terminal while idle");
  AST_RST_PULSE: assert property (FAULT_RESET_O |-> !FAULT_ACTIVE_O ##1 !FAULT_RESET_O)
    else $error("bad reset pulse");
  AST_GND_W: assert property ($fell(MOTOR_PHASE_OUTPUTS_EN_O) |-> gnd_q == GND_W)
    else $error("ground check pulse width");
  C_HOLD: cover property ($rose(RAMP_HOLD_O));
  C_RST: cover property (FAULT_RESET_O);
  C_GND: cover property ($rose(MOTOR_PHASE_OUTPUTS_EN_O));
endmodule // dfp_assertions
bind dfp_top dfp_assertions #(.MS_CYCLES(MS_CYCLES)) u_dfp_assertions (
  .REF_CLK_I(REF_CLK_I), .RESET_N_I(RESET_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .OUT_CURRENT_I(OUT_CURRENT_I),
  .BUS_VOLTAGE_I(BUS_VOLTAGE_I), .ACCEL_I(ACCEL_I), .DECEL_I(DECEL_I), .RAMP_HOLD_O(RAMP_HOLD_O),
  .MOTOR_PHASE_OUTPUTS_EN_O(MOTOR_PHASE_OUTPUTS_EN_O), .FAULT_ACTIVE_O(FAULT_ACTIVE_O),
  .FAULT_TERMINAL_O(FAULT_TERMINAL_O), .FAULT_RESET_O(FAULT_RESET_O));

//--- sim/tb_drive_fault_protection.sv
// Self-checking bench of the fault supervisor
`timescale 1ns/100ps
module tb_drive_fault_protection;
  logic        clk, rst_n, psel, pen, pwr, rdy, serr, serr_q, fev, hold, mph, fact, fterm, frst, acc, dec, opl, warn;
  logic [7:0]  paddr, fcode;
  logic [31:0] pwd, prd, rd;
  logic [15:0] cur, bus, freq, tgt, f0;
  logic [9:0]  din;
  logic [4:0]  dout;
  int          fails, check_count, n, nrst, gnd;
  dfp_top #(.MS_CYCLES(10)) u_dfp_top (
    .REF_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(serr),
    .OUT_FREQ_I(freq), .OUT_CURRENT_I(cur), .BUS_VOLTAGE_I(bus), .ACCEL_I(acc), .DECEL_I(dec),
    .FAULT_EVENT_I(fev), .FAULT_CODE_I(fcode), .INPUT_PHASE_LOSS_I(1'b0), .CONTACTOR_FAULT_I(1'b0),
    .OUTPUT_PHASE_LOSS_I(opl), .LOGIC_INPUT_TERMINAL_I(din), .OUT_TERMINALS_I(dout),
    .VOLTAGE_CLASS_I(3'h2), .POWER_QUALIFIED_I(1'b0), .OVERLOAD_WARN_O(warn), .RAMP_HOLD_O(hold),
    .MOTOR_PHASE_OUTPUTS_EN_O(mph), .FAULT_ACTIVE_O(fact), .FAULT_TERMINAL_O(fterm), .FAULT_RESET_O(frst));
  dfp_drive_model u_dfp_drive_model (
    .clk_i(clk), .rst_n_i(rst_n), .hold_i(hold), .target_i(tgt), .freq_o(freq), .accel_o(acc), .decel_o(dec));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (frst === 1'b1) nrst <= nrst + 1;
    if (mph === 1'b1) gnd <= gnd + 1;
  end
  task automatic final_report(input int t);
    fails += t;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      if (rdy === 1'b1) break;
    end
    rd = prd;
    serr_q = serr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (i == 8) final_report(1);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic pulse(input logic [7:0] c);
    @(posedge clk);
    fev <= 1'b1;
    fcode <= c;
    @(posedge clk);
    fev <= 1'b0;
    f0 = freq;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  initial begin
    {rst_n, psel, pen, pwr, fev, opl, paddr, fcode, pwd} = '0;
    {cur, bus, tgt, din, dout} = {16'h0064, 16'h012c, 16'h0000, 10'h001, 5'h15};
    cyc(12);
    rst_n <= 1'b1;
    rdc(dfp_pkg::OFS_CFG0, 32'h00820050);
    rdc(dfp_pkg::OFS_CFG1, 32'h00009614);
    rdc(dfp_pkg::OFS_CFG2, 32'h000b0600);
    rdc(dfp_pkg::OFS_INTERVAL, 32'h0000000a);
    rdc(dfp_pkg::OFS_FT_LAST, 32'h0);
    rdc(8'h1c, 32'h0);
    chk(32'(serr_q), 32'h1);
    apb(1'b1, dfp_pkg::OFS_CFG0, 32'h0);
    rdc(dfp_pkg::OFS_CFG0, 32'h00780032);
    $display("test registers done");
    tgt <= 16'h0100;
    cur <= 16'h0640;
    cyc(3);
    chk(32'(hold), 32'h1);
    f0 = freq;
    cyc(4);
    chk(32'(freq), 32'(f0));
    cur <= 16'h0578;
    cyc(3);
    chk(32'(hold), 32'h0);
    apb(1'b1, dfp_pkg::OFS_CFG1, 32'h00009600);
    cur <= 16'h0640;
    cyc(3);
    chk(32'(hold), 32'h0);
    cur <= 16'h0064;
    apb(1'b1, dfp_pkg::OFS_CFG0, 32'h00820150);
    cyc(40);
    tgt <= 16'h0000;
    bus <= 16'h02b2;
    cyc(3);
    chk(32'(hold), 32'h1);
    bus <= 16'h02b1;
    cyc(3);
    chk(32'(hold), 32'h0);
    bus <= 16'h012c;
    $display("test stall done");
    apb(1'b1, dfp_pkg::OFS_CFG2, 32'h000b0701);
    apb(1'b1, dfp_pkg::OFS_INTERVAL, 32'h1);
    pulse(8'h05);
    cyc(2);
    chk(32'(fterm), 32'h1);
    for (n = 0; n < 1200 && nrst == 0; n++) cyc(1);
    if (nrst == 0) final_report(1);
    chk(32'(n > 990 && n < 1010), 32'h1);
    rdc(dfp_pkg::OFS_FT_LAST, 32'h5);
    rdc(dfp_pkg::OFS_FT_SECND, 32'h0);
    rdc(dfp_pkg::OFS_SNAP_IN, 32'h200);
    rdc(dfp_pkg::OFS_SNAP_OUT, 32'h15);
    rdc(dfp_pkg::OFS_SNAP_CUR, 32'h64);
    rdc(dfp_pkg::OFS_SNAP_BUS, 32'h12c);
    rdc(dfp_pkg::OFS_SNAP_FRQ, 32'(f0));
    pulse(8'h07);
    cyc(1200);
    chk(32'(fact), 32'h1);
    rdc(dfp_pkg::OFS_FT_SECND, 32'h5);
    apb(1'b1, dfp_pkg::OFS_CTRL, 32'h1);
    cyc(2);
    chk(32'(fact), 32'h0);
    chk(32'(nrst), 32'h2);
    pulse(8'h96);
    rdc(dfp_pkg::OFS_FT_LAST, 32'h63);
    rdc(dfp_pkg::OFS_FT_FIRST, 32'h5);
    apb(1'b1, dfp_pkg::OFS_CFG2, 32'h000b0201);
    cyc(1);
    chk(32'({fact, fterm}), 32'h2);
    opl <= 1'b1;
    apb(1'b1, dfp_pkg::OFS_CTRL, 32'h1);
    cyc(2);
    chk(32'(fact), 32'h0);
    apb(1'b1, dfp_pkg::OFS_CFG2, 32'h000b0601);
    rdc(dfp_pkg::OFS_FT_LAST, 32'hd);
    chk(32'(gnd), 32'h64);
    apb(1'b1, dfp_pkg::OFS_OL_GAIN, 32'h14);
    apb(1'b1, dfp_pkg::OFS_CFG0, 32'h00820132);
    cur <= 16'hffff;
    cyc(600);
    chk(32'(warn), 32'h0);
    cyc(100);
    chk(32'(warn), 32'h1);
    $display("test faults done");
    final_report(0);
  end
endmodule // tb_drive_fault_protection
